// *** hart_bus_poller.sv ***
// One HART bus master poller: walks polling addresses 0..15 in a loop
// Assumes a modem on the same clock that gives a done pulse for each answer it receives
`timescale 1ns/100ps
`include "hart_ctrl_defines.svh"

module hart_bus_poller #(
  parameter int unsigned TIMEOUT_CYC = `RESP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic                      clk_in,
  input  wire logic                      rstn_in,
  // Control
  input  wire logic                      enable_in,
  // Modem side
  output logic                           tx_start_out,
  output hart_ctrl_pkg::poll_addr_t      tx_addr_out,
  input  wire logic                      rx_done_in,
  input  wire logic                      rx_ack_in,
  // Result side, held until taken; cycle start is a one-cycle pulse at each address-0 poll
  output logic                           res_valid_out,
  output logic                           res_ack_out,
  output logic                           cycle_start_out,
  input  wire logic                      res_take_in
);

  typedef enum logic [1:0] {IDLE, WAIT, HOLD} poll_state_e;

  poll_state_e state;
  logic [31:0] timer;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state           <= IDLE;
      tx_start_out    <= 1'b0;
      tx_addr_out     <= 4'h0;
      res_valid_out   <= 1'b0;
      res_ack_out     <= 1'b0;
      cycle_start_out <= 1'b0;
      timer           <= 32'h0;
    end else begin
      tx_start_out    <= 1'b0;
      cycle_start_out <= 1'b0;
      unique case (state)
        IDLE: begin
          if (enable_in) begin
            tx_start_out    <= 1'b1;
            cycle_start_out <= (tx_addr_out == 4'h0);
            timer           <= 32'h0;
            state           <= WAIT;
          end
        end
        WAIT: begin
          // A silent address must not stall the loop, so a timeout ends the wait
          if (rx_done_in || timer == TIMEOUT_CYC - 1) begin
            res_valid_out <= 1'b1;
            res_ack_out   <= rx_done_in && rx_ack_in;
            state         <= HOLD;
          end else begin
            timer <= timer + 32'h1;
          end
        end
        HOLD: begin
          if (res_take_in) begin
            res_valid_out <= 1'b0;
            tx_addr_out   <= tx_addr_out + 4'h1;
            state         <= IDLE;
          end
        end
      endcase
    end
  end

endmodule // hart_bus_poller

// *** hart_ctrl_defines.svh ***
// Offsets, field positions, reset values and timing counts of the HART mode controller
// Assumes inclusion by bare name from the files that use its macros
`ifndef HART_CTRL_DEFINES_SVH
`define HART_CTRL_DEFINES_SVH

`define REG_CTRL        4'h0
`define REG_IS_ADDR     4'h1
`define REG_FD_ADDR     4'h2
`define REG_SLAVE_VALUE 4'h3
`define REG_STATUS      4'h4
`define REG_MASK        4'h5
`define REG_STATE       4'h6

`define CTRL_MODE_LSB   0
`define CTRL_MODE_MSB   1

`define ST_NEW_DEV      0
`define ST_ADDR_ALARM   1
`define ST_SLAVE_HIT    2
`define ST_CYCLE_DONE   3

`define IS_ADDR_RST     4'hf
`define FD_ADDR_RST     4'h0
`define SLAVE_VAL_RST   16'h0000
`define MASK_RST        4'h0

`define CLK_MHZ         100
`define RESP_TIMEOUT_US 500
`define RESP_TIMEOUT_CYC (`RESP_TIMEOUT_US * `CLK_MHZ)

`endif

// *** hart_ctrl_pkg.sv ***
// Types of the HART mode controller
// Assumes the defines header is compiled alongside
package hart_ctrl_pkg;

  typedef enum logic [1:0] {
    MODE_CURRENT_ONLY = 2'h0,
    MODE_SLAVE        = 2'h1,
    MODE_MASTER       = 2'h2
  } fd_mode_e;

  typedef logic [3:0] poll_addr_t;

endpackage

// *** hart_dev_table.sv ***
// Table of found field devices: one presence bit per bus for each polling address
// Assumes one write and one read per cycle; read data come from a register
`timescale 1ns/100ps

module hart_dev_table (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [3:0] wr_addr_in,
  input  wire logic [1:0] wr_data_in,
  // Read port
  input  wire logic [3:0] rd_addr_in,
  output logic      [1:0] rd_data_out
);

  logic [1:0] mem [16];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < 16; i++) begin
        mem[i] <= 2'h0;
      end
    end else if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_data_out <= 2'h0;
    end else begin
      rd_data_out <= mem[rd_addr_in];
    end
  end

endmodule // hart_dev_table

// *** hart_dual_interface_mode_ctrl.sv ***
// Mode controller for the two HART interfaces: polling masters, slave address match,
// loop current selection, device table with address alarm, register port and interrupt
// Assumes HART modems on the same clock, one per bus, with pulse-level handshakes
//
// Behaviour
// - Safe side always polls as master
// - Safe side also answers as slave
// - Current-only mode: no HART, live current
// - Slave mode answers external masters on flameproof
// - Master mode polls flameproof bus too
// - Safe-side slave address register, reset 15
// - Flameproof address reset 0: HART plus live
// - Address 1..15 fixes current for multidrop
// - Both slaves report one shared value
// - Master mode slave answers on both buses
// - Master mode uses safe-side address only
// - Slave mode loops independent, duplicates allowed
// - Alarm on duplicate or zero polled address
// - Continuous scan flags newly found devices
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`include "hart_ctrl_defines.svh"

module hart_dual_interface_mode_ctrl #(
  parameter int unsigned RESP_TIMEOUT_CYC = `RESP_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // Interrupt
  output logic             irq_out,
  // Safe-side modem, master role
  output logic             is_tx_start_out,
  output logic      [3:0]  is_tx_addr_out,
  input  wire logic        is_rx_done_in,
  input  wire logic        is_rx_ack_in,
  // Flameproof-side modem, master role
  output logic             fd_tx_start_out,
  output logic      [3:0]  fd_tx_addr_out,
  input  wire logic        fd_rx_done_in,
  input  wire logic        fd_rx_ack_in,
  // Slave requests from both modems
  input  wire logic        is_slave_req_in,
  input  wire logic [3:0]  is_slave_addr_in,
  input  wire logic        fd_slave_req_in,
  input  wire logic [3:0]  fd_slave_addr_in,
  output logic             is_slave_reply_out,
  output logic             fd_slave_reply_out,
  output logic      [15:0] slave_value_out,
  // Flameproof analog output group
  output logic             fd_hart_en_out,
  output logic             fd_loop_live_out,
  output logic             fd_loop_fixed_out
);

  // Configuration registers
  hart_ctrl_pkg::fd_mode_e   cfg_mode;
  hart_ctrl_pkg::fd_mode_e   active_mode;
  hart_ctrl_pkg::poll_addr_t is_addr;
  hart_ctrl_pkg::poll_addr_t fd_addr;
  logic [15:0]               slave_value;
  logic [3:0]                status;
  logic [3:0]                mask;
  logic [3:0]                next_status;

  // Poller and table wiring
  logic       is_res_valid;
  logic       is_res_ack;
  logic       is_cycle_start;
  logic       fd_res_valid;
  logic       fd_res_ack;
  logic       fd_cycle_start;
  logic       is_take;
  logic       fd_take;
  logic       fd_poll_en;
  logic       tbl_wr;
  logic [3:0] tbl_wr_addr;
  logic [1:0] tbl_wr_data;
  logic [3:0] tbl_rd_addr;
  logic [1:0] tbl_rd_data;

  // Two-stage check: read entry, then compare and write back
  logic       chk_valid;
  logic       chk_bus_fd;
  logic       chk_ack;
  logic [3:0] chk_addr;
  logic       ev_new_dev;
  logic       ev_addr_alarm;
  logic       ev_slave_hit;
  logic       is_hit;
  logic       fd_hit;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_mode    <= hart_ctrl_pkg::MODE_CURRENT_ONLY;
      is_addr     <= `IS_ADDR_RST;
      fd_addr     <= `FD_ADDR_RST;
      slave_value <= `SLAVE_VAL_RST;
      mask        <= `MASK_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        `REG_CTRL: begin
          // An unused encoding is refused and the old mode kept
          if (reg_wdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB] != 2'h3) begin
            cfg_mode <= hart_ctrl_pkg::fd_mode_e'(reg_wdata_in[`CTRL_MODE_MSB:`CTRL_MODE_LSB]);
          end
        end
        `REG_IS_ADDR:     is_addr     <= reg_wdata_in[3:0];
        `REG_FD_ADDR:     fd_addr     <= reg_wdata_in[3:0];
        `REG_SLAVE_VALUE: slave_value <= reg_wdata_in;
        `REG_MASK:        mask        <= reg_wdata_in[3:0];
        default: begin
        end
      endcase
    end
  end

  // The running mode changes only at the start of a safe-side poll cycle,
  // so a cycle never mixes the one-bus and two-bus scan
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      active_mode <= hart_ctrl_pkg::MODE_CURRENT_ONLY;
    end else if (is_cycle_start) begin
      active_mode <= cfg_mode;
    end
  end

  assign fd_poll_en = (active_mode == hart_ctrl_pkg::MODE_MASTER);

  hart_bus_poller #(
    .TIMEOUT_CYC (RESP_TIMEOUT_CYC)
  ) u_is_poller (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .enable_in       (1'b1),
    .tx_start_out    (is_tx_start_out),
    .tx_addr_out     (is_tx_addr_out),
    .rx_done_in      (is_rx_done_in),
    .rx_ack_in       (is_rx_ack_in),
    .res_valid_out   (is_res_valid),
    .res_ack_out     (is_res_ack),
    .cycle_start_out (is_cycle_start),
    .res_take_in     (is_take)
  );

  hart_bus_poller #(
    .TIMEOUT_CYC (RESP_TIMEOUT_CYC)
  ) u_fd_poller (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .enable_in       (fd_poll_en),
    .tx_start_out    (fd_tx_start_out),
    .tx_addr_out     (fd_tx_addr_out),
    .rx_done_in      (fd_rx_done_in),
    .rx_ack_in       (fd_rx_ack_in),
    .res_valid_out   (fd_res_valid),
    .res_ack_out     (fd_res_ack),
    .cycle_start_out (fd_cycle_start),
    .res_take_in     (fd_take)
  );

  // Safe side has priority; a result waits in its poller until taken
  assign is_take     = is_res_valid && !chk_valid;
  assign fd_take     = fd_res_valid && !is_res_valid && !chk_valid;
  assign tbl_rd_addr = is_take ? is_tx_addr_out : fd_tx_addr_out;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      chk_valid  <= 1'b0;
      chk_bus_fd <= 1'b0;
      chk_ack    <= 1'b0;
      chk_addr   <= 4'h0;
    end else begin
      chk_valid <= is_take || fd_take;
      if (is_take) begin
        chk_bus_fd <= 1'b0;
        chk_ack    <= is_res_ack;
        chk_addr   <= is_tx_addr_out;
      end else if (fd_take) begin
        chk_bus_fd <= 1'b1;
        chk_ack    <= fd_res_ack;
        chk_addr   <= fd_tx_addr_out;
      end
    end
  end

  hart_dev_table u_table (
    .clk_in      (clk_in),
    .rstn_in     (rstn_in),
    .wr_en_in    (tbl_wr),
    .wr_addr_in  (tbl_wr_addr),
    .wr_data_in  (tbl_wr_data),
    .rd_addr_in  (tbl_rd_addr),
    .rd_data_out (tbl_rd_data)
  );

  // Bit 0 marks presence on the safe bus, bit 1 on the flameproof bus
  assign tbl_wr      = chk_valid;
  assign tbl_wr_addr = chk_addr;
  assign tbl_wr_data = chk_bus_fd ? {chk_ack, tbl_rd_data[0]} : {tbl_rd_data[1], chk_ack};

  // A device that stops answering drops out, so it counts as new when it returns
  assign ev_new_dev = chk_valid && chk_ack &&
                      !(chk_bus_fd ? tbl_rd_data[1] : tbl_rd_data[0]);

  // Zero address is always an alarm; a shared address only matters while
  // both buses belong to one master, since slave mode keeps the loops apart
  assign ev_addr_alarm = chk_valid && chk_ack &&
                         ((chk_addr == 4'h0) ||
                          (fd_poll_en &&
                           (chk_bus_fd ? tbl_rd_data[0] : tbl_rd_data[1])));

  // Slave address match per bus and mode
  always_comb begin
    is_hit = is_slave_req_in && (is_slave_addr_in == is_addr);
    unique case (active_mode)
      hart_ctrl_pkg::MODE_SLAVE:  fd_hit = fd_slave_req_in && (fd_slave_addr_in == fd_addr);
      hart_ctrl_pkg::MODE_MASTER: fd_hit = fd_slave_req_in && (fd_slave_addr_in == is_addr);
      default:                    fd_hit = 1'b0;
    endcase
  end

  assign ev_slave_hit = is_hit || fd_hit;

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      is_slave_reply_out <= 1'b0;
      fd_slave_reply_out <= 1'b0;
      slave_value_out    <= `SLAVE_VAL_RST;
    end else begin
      is_slave_reply_out <= is_hit;
      fd_slave_reply_out <= fd_hit;
      slave_value_out    <= slave_value;
    end
  end

  // Analog output group of the flameproof side
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      fd_hart_en_out    <= 1'b0;
      fd_loop_live_out  <= 1'b1;
      fd_loop_fixed_out <= 1'b0;
    end else begin
      unique case (active_mode)
        hart_ctrl_pkg::MODE_SLAVE: begin
          fd_hart_en_out    <= 1'b1;
          fd_loop_live_out  <= (fd_addr == 4'h0);
          fd_loop_fixed_out <= (fd_addr != 4'h0);
        end
        hart_ctrl_pkg::MODE_MASTER: begin
          fd_hart_en_out    <= 1'b1;
          fd_loop_live_out  <= 1'b0;
          fd_loop_fixed_out <= 1'b1;
        end
        default: begin
          fd_hart_en_out    <= 1'b0;
          fd_loop_live_out  <= 1'b1;
          fd_loop_fixed_out <= 1'b0;
        end
      endcase
    end
  end

  // Sticky status: an event in the cycle of a clearing read survives
  always_comb begin
    next_status = status;
    if (reg_rd_in && reg_addr_in == `REG_STATUS) begin
      next_status = 4'h0;
    end
    next_status[`ST_NEW_DEV]    = next_status[`ST_NEW_DEV] | ev_new_dev;
    next_status[`ST_ADDR_ALARM] = next_status[`ST_ADDR_ALARM] | ev_addr_alarm;
    next_status[`ST_SLAVE_HIT]  = next_status[`ST_SLAVE_HIT] | ev_slave_hit;
    next_status[`ST_CYCLE_DONE] = next_status[`ST_CYCLE_DONE] | is_cycle_start;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      status  <= 4'h0;
      irq_out <= 1'b0;
    end else begin
      status  <= next_status;
      irq_out <= |(next_status & mask);
    end
  end

  // Read data stand one cycle after the strobe; unmapped offsets read zero
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      reg_rdata_out <= 16'h0000;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `REG_CTRL:        reg_rdata_out <= {14'h0, cfg_mode};
        `REG_IS_ADDR:     reg_rdata_out <= {12'h0, is_addr};
        `REG_FD_ADDR:     reg_rdata_out <= {12'h0, fd_addr};
        `REG_SLAVE_VALUE: reg_rdata_out <= slave_value;
        `REG_STATUS:      reg_rdata_out <= {12'h0, status};
        `REG_MASK:        reg_rdata_out <= {12'h0, mask};
        `REG_STATE:       reg_rdata_out <= {10'h0, fd_poll_en, fd_cycle_start,
                                            is_res_valid, fd_res_valid, active_mode};
        default:          reg_rdata_out <= 16'h0000;
      endcase
    end else begin
      reg_rdata_out <= 16'h0000;
    end
  end

endmodule // hart_dual_interface_mode_ctrl

// *** hart_field_model.sv ***
// Field-bus model: HART instruments on one bus answering the controller's polls
// Assumes the poller's registered start pulse and the block's clock
`timescale 1ns/100ps

module hart_field_model #(
  parameter int DELAY = 2
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // Poll from the controller
  input  wire logic        tx_start_in,
  input  wire logic [3:0]  tx_addr_in,
  input  wire logic [15:0] present_in,
  // Modem answer
  output logic             rx_done_out,
  output logic             rx_ack_out
);
  int cnt;
  // Absent addresses stay silent, so the poller has to run its timeout
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt         <= 0;
      rx_done_out <= 1'b0;
      rx_ack_out  <= 1'b0;
    end else begin
      rx_done_out <= 1'b0;
      rx_ack_out  <= ~rx_ack_out;
      if (tx_start_in && present_in[tx_addr_in]) begin
        cnt <= DELAY;
      end else if (cnt == 1) begin
        cnt         <= 0;
        rx_done_out <= 1'b1;
        rx_ack_out  <= 1'b1;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule // hart_field_model

// *** hart_mode_ctrl_sva.sv ***
// Checker for the HART mode controller ports
// Assumes binding to the top module, one clock domain
`timescale 1ns/100ps
`include "hart_ctrl_defines.svh"

module hart_mode_ctrl_sva (
  // Clock, reset and register writes
  input wire logic        clk_in,
  input wire logic        rstn_in,
  input wire logic [3:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  // Safe side
  input wire logic        is_tx_start_out,
  input wire logic [3:0]  is_tx_addr_out,
  input wire logic        is_rx_done_in,
  input wire logic        is_slave_req_in,
  input wire logic [3:0]  is_slave_addr_in,
  input wire logic        is_slave_reply_out,
  // Flameproof side
  input wire logic        fd_tx_start_out,
  input wire logic        fd_slave_req_in,
  input wire logic        fd_slave_reply_out,
  input wire logic        fd_hart_en_out,
  input wire logic        fd_loop_live_out,
  input wire logic        fd_loop_fixed_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Shadow of the safe-side address, updated on the same edge as the design's copy
  logic [3:0] is_addr;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) is_addr <= `IS_ADDR_RST;
    else if (reg_wr_in && reg_addr_in == `REG_IS_ADDR) is_addr <= reg_wdata_in[3:0];
  end
  sequence s_restart;
    ##[2:6] is_tx_start_out;
  endsequence
  property p_is_slave;
    is_slave_req_in |=> is_slave_reply_out == ($past(is_slave_addr_in) == $past(is_addr));
  endproperty
  property p_fd_reply;
    fd_slave_reply_out |-> $past(fd_slave_req_in) && fd_hart_en_out;
  endproperty
  property p_quiet;
    !fd_hart_en_out |-> fd_loop_live_out && !fd_loop_fixed_out;
  endproperty
  property p_fixed;
    fd_loop_fixed_out |-> fd_hart_en_out && !fd_loop_live_out;
  endproperty
  property p_fd_poll;
    fd_tx_start_out |-> fd_hart_en_out && fd_loop_fixed_out;
  endproperty
  property p_repoll;
    is_rx_done_in |-> s_restart;
  endproperty
  // The address steps in the idle cycle, one cycle ahead of the start that uses it
  property p_addr_stable;
    $changed(is_tx_addr_out) |=> is_tx_start_out;
  endproperty
  property p_addr_step;
    is_tx_start_out && is_tx_addr_out != 4'h0 |-> is_tx_addr_out == $past(is_tx_addr_out, 2) + 4'h1;
  endproperty
  a_is_slave: assert property (p_is_slave) else $error("safe slave reply wrong");
  a_fd_reply: assert property (p_fd_reply) else $error("flameproof reply uncaused");
  a_quiet: assert property (p_quiet) else $error("no HART but current not live");
  a_fixed: assert property (p_fixed) else $error("fixed current without HART");
  a_fd_poll: assert property (p_fd_poll) else $error("flameproof poll outside master");
  a_repoll: assert property (p_repoll) else $error("safe poll did not go on");
  a_addr_stable: assert property (p_addr_stable) else $error("poll address moved");
  a_addr_step: assert property (p_addr_step) else $error("poll address skipped");
endmodule // hart_mode_ctrl_sva

bind hart_dual_interface_mode_ctrl hart_mode_ctrl_sva u_sva (
  .clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .is_tx_start_out,
  .is_tx_addr_out, .is_rx_done_in, .is_slave_req_in, .is_slave_addr_in, .is_slave_reply_out,
  .fd_tx_start_out, .fd_slave_req_in, .fd_slave_reply_out, .fd_hart_en_out,
  .fd_loop_live_out, .fd_loop_fixed_out
);

// *** tb.sv ***
// Self-checking bench for the HART mode controller
// Assumes one field-bus model per bus and the bound checker
`timescale 1ns/100ps
`include "hart_ctrl_defines.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end

module tb;
  logic        clk_in, rstn_in, reg_wr_in, reg_rd_in, irq_out;
  logic [3:0]  reg_addr_in, is_tx_addr_out, fd_tx_addr_out, is_slave_addr_in, fd_slave_addr_in;
  logic [15:0] reg_wdata_in, reg_rdata_out, slave_value_out, is_present, fd_present;
  logic        is_tx_start_out, is_rx_done_in, is_rx_ack_in, fd_tx_start_out, fd_rx_done_in;
  logic        fd_rx_ack_in, is_slave_req_in, fd_slave_req_in, is_slave_reply_out;
  logic        fd_slave_reply_out, fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out;
  int          err_total = 0;
  int          compares = 0;

  // Short timeout keeps a poll cycle of silent addresses to a few hundred clocks
  hart_dual_interface_mode_ctrl #(.RESP_TIMEOUT_CYC(20)) dut (
    .clk_in, .rstn_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
    .irq_out, .is_tx_start_out, .is_tx_addr_out, .is_rx_done_in, .is_rx_ack_in,
    .fd_tx_start_out, .fd_tx_addr_out, .fd_rx_done_in, .fd_rx_ack_in, .is_slave_req_in,
    .is_slave_addr_in, .fd_slave_req_in, .fd_slave_addr_in, .is_slave_reply_out,
    .fd_slave_reply_out, .slave_value_out, .fd_hart_en_out, .fd_loop_live_out, .fd_loop_fixed_out
  );
  hart_field_model #(.DELAY(2)) is_bus (.clk_in, .rstn_in, .tx_start_in(is_tx_start_out),
    .tx_addr_in(is_tx_addr_out), .present_in(is_present), .rx_done_out(is_rx_done_in),
    .rx_ack_out(is_rx_ack_in));
  hart_field_model #(.DELAY(15)) fd_bus (.clk_in, .rstn_in, .tx_start_in(fd_tx_start_out),
    .tx_addr_in(fd_tx_addr_out), .present_in(fd_present), .rx_done_out(fd_rx_done_in),
    .rx_ack_out(fd_rx_ack_in));

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    @(negedge clk_in);
    v = reg_rdata_out;
  endtask
  // Mode and status settle per poll cycle, so wait for two starts of address 0
  task automatic cyc();
    int n;
    repeat (2) begin
      n = 0;
      do begin
        @(negedge clk_in);
        n++;
      end while (!(is_tx_start_out === 1'b1 && is_tx_addr_out === 4'h0) && n < 3000);
      if (n >= 3000) begin
        err_total++;
        end_of_test();
      end
    end
    repeat (4) @(negedge clk_in);
  endtask
  // Requests on both buses at once; replies are judged at the following negedge
  task automatic sreq(input logic [3:0] ia, input logic [3:0] fa);
    @(posedge clk_in);
    is_slave_req_in <= 1'b1;
    fd_slave_req_in <= 1'b1;
    is_slave_addr_in <= ia;
    fd_slave_addr_in <= fa;
    @(posedge clk_in);
    is_slave_req_in <= 1'b0;
    fd_slave_req_in <= 1'b0;
    is_slave_addr_in <= ~ia;
    fd_slave_addr_in <= ~fa;
    @(negedge clk_in);
  endtask

  task automatic t_reset_regs();
    logic [15:0] v;
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b010)
    rd(`REG_IS_ADDR, v);
    `CHK(v, 16'h000f)
    rd(`REG_FD_ADDR, v);
    `CHK(v, 16'h0000)
    wr(`REG_CTRL, 16'h0003);
    rd(`REG_CTRL, v);
    `CHK(v, 16'h0000)
    rd(4'hf, v);
    `CHK(v, 16'h0000)
  endtask
  task automatic t_poll_irq();
    logic [15:0] v;
    wr(`REG_MASK, 16'h0001);
    cyc();
    `CHK(irq_out, 1'b1)
    rd(`REG_STATUS, v);
    `CHK(v & 16'h0003, 16'h0001)
    `CHK(irq_out, 1'b0)
    cyc();
    `CHK(irq_out, 1'b0)
    is_present <= 16'h003e;
    cyc();
    `CHK(irq_out, 1'b1)
    rd(`REG_STATUS, v);
  endtask
  task automatic t_slave();
    wr(`REG_SLAVE_VALUE, 16'h5a3c);
    wr(`REG_CTRL, 16'h0001);
    cyc();
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b110)
    `CHK(slave_value_out, 16'h5a3c)
    sreq(4'hf, 4'h0);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b11)
    wr(`REG_FD_ADDR, 16'h0005);
    wr(`REG_IS_ADDR, 16'h0005);
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b101)
    sreq(4'h5, 4'h5);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b11)
    sreq(4'hf, 4'h0);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b00)
  endtask
  task automatic t_master();
    logic [15:0] v;
    fd_present <= 16'h0082;
    wr(`REG_FD_ADDR, 16'h0007);
    wr(`REG_CTRL, 16'h0002);
    cyc();
    cyc();
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b101)
    rd(`REG_STATUS, v);
    `CHK(v & 16'h0003, 16'h0003)
    rd(`REG_STATE, v);
    `CHK(v & 16'h0023, 16'h0022)
    sreq(4'h5, 4'h5);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b11)
    sreq(4'h7, 4'h7);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b00)
  endtask
  task automatic t_back();
    logic [15:0] v;
    fd_present <= 16'h0000;
    is_present <= 16'h003f;
    wr(`REG_CTRL, 16'h0000);
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b101)
    cyc();
    `CHK({fd_hart_en_out, fd_loop_live_out, fd_loop_fixed_out}, 3'b010)
    sreq(4'h5, 4'h5);
    `CHK({is_slave_reply_out, fd_slave_reply_out}, 2'b10)
    // Clear alarms left from master mode, so only the zero address can set it again
    rd(`REG_STATUS, v);
    cyc();
    rd(`REG_STATUS, v);
    `CHK(v & 16'h0002, 16'h0002)
  endtask
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // About 4.5k clocks are expected; the limit of 30k leaves a wide margin
  initial begin
    #300000;
    err_total++;
    end_of_test();
  end
  initial begin
    rstn_in = 1'b0;
    {reg_wr_in, reg_rd_in, is_slave_req_in, fd_slave_req_in} = 4'h0;
    {reg_addr_in, is_slave_addr_in, fd_slave_addr_in} = 12'h000;
    reg_wdata_in = 16'h0000;
    // Level and pressures only, address 2 left free and address 0 unused
    is_present = 16'h003a;
    fd_present = 16'h0000;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_reset_regs();
    t_poll_irq();
    t_slave();
    t_master();
    t_back();
    end_of_test();
  end
endmodule // tb
